// [rtl/gpo_pkg.sv]
// Constants, register indices and carrier types for the GPIO port block.
// Assumes a 32-bit APB master and 17 pins sampled on the system clock.
package gpo_pkg;

  // Port geometry
  localparam int NUM_PINS = 17;
  localparam int LOW_W = 16;
  localparam int HIGH_BIT = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 16;
  localparam int ADDR_W = 18;
  localparam int IDX_LSB = 2;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_PIN_INPUT_LOW = 16'h4702;
  localparam logic [15:0] IDX_OUTPUT_LEVEL_HIGH = 16'h4704;
  localparam logic [15:0] IDX_OUTPUT_LEVEL_LOW = 16'h4706;
  localparam logic [15:0] IDX_OUTPUT_SET_HIGH = 16'h4708;
  localparam logic [15:0] IDX_OUTPUT_SET_LOW = 16'h470A;
  localparam logic [15:0] IDX_OUTPUT_CLEAR_HIGH = 16'h470C;
  localparam logic [15:0] IDX_OUTPUT_CLEAR_LOW = 16'h470E;
  localparam logic [15:0] IDX_OUTPUT_ENABLE_HIGH = 16'h4714;
  localparam logic [15:0] IDX_OUTPUT_ENABLE_LOW = 16'h4716;
  localparam logic [15:0] IDX_OUTPUT_ENABLE_SET_HIGH = 16'h4718;
  localparam logic [15:0] IDX_OUTPUT_ENABLE_SET_LOW = 16'h471A;

  // Reset values
  localparam logic [16:0] RESET_PINS = 17'h00000;
  localparam logic [31:0] RESET_RDATA = 32'h00000000;

  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_PIN_INPUT_LOW,
    SEL_OUTPUT_LEVEL_HIGH,
    SEL_OUTPUT_LEVEL_LOW,
    SEL_OUTPUT_SET_HIGH,
    SEL_OUTPUT_SET_LOW,
    SEL_OUTPUT_CLEAR_HIGH,
    SEL_OUTPUT_CLEAR_LOW,
    SEL_OUTPUT_ENABLE_HIGH,
    SEL_OUTPUT_ENABLE_LOW,
    SEL_OUTPUT_ENABLE_SET_HIGH,
    SEL_OUTPUT_ENABLE_SET_LOW
  } gpo_sel_type;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_WRITE,
    OP_SET,
    OP_CLEAR
  } gpo_op_type;

  // Update command for a pin register
  typedef struct packed {
    gpo_op_type op;
    logic [16:0] mask;
    logic [16:0] data;
  } gpo_cmd_type;

  // Register index decode
  function automatic gpo_sel_type gpo_decode(input logic [15:0] idx);
    gpo_sel_type sel;
    sel = SEL_NONE;
    case (idx)
      IDX_PIN_INPUT_LOW: sel = SEL_PIN_INPUT_LOW;
      IDX_OUTPUT_LEVEL_HIGH: sel = SEL_OUTPUT_LEVEL_HIGH;
      IDX_OUTPUT_LEVEL_LOW: sel = SEL_OUTPUT_LEVEL_LOW;
      IDX_OUTPUT_SET_HIGH: sel = SEL_OUTPUT_SET_HIGH;
      IDX_OUTPUT_SET_LOW: sel = SEL_OUTPUT_SET_LOW;
      IDX_OUTPUT_CLEAR_HIGH: sel = SEL_OUTPUT_CLEAR_HIGH;
      IDX_OUTPUT_CLEAR_LOW: sel = SEL_OUTPUT_CLEAR_LOW;
      IDX_OUTPUT_ENABLE_HIGH: sel = SEL_OUTPUT_ENABLE_HIGH;
      IDX_OUTPUT_ENABLE_LOW: sel = SEL_OUTPUT_ENABLE_LOW;
      IDX_OUTPUT_ENABLE_SET_HIGH: sel = SEL_OUTPUT_ENABLE_SET_HIGH;
      IDX_OUTPUT_ENABLE_SET_LOW: sel = SEL_OUTPUT_ENABLE_SET_LOW;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  // Build a command for the high bit or the low half of a pin register
  function automatic gpo_cmd_type gpo_place(input gpo_op_type op,
                                            input logic is_high,
                                            input logic [31:0] wdata);
    gpo_cmd_type cmd;
    cmd.op = op;
    if (is_high) begin
      cmd.mask = {1'h1, 16'h0000};
      cmd.data = {wdata[0], 16'h0000};
    end else begin
      cmd.mask = {1'h0, 16'hFFFF};
      cmd.data = {1'h0, wdata[15:0]};
    end
    return cmd;
  endfunction

endpackage

// [rtl/gpo_pin_sampler.sv]
// Input sampling register for the pin levels.
// Assumes pin inputs are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module gpo_pin_sampler #(
  parameter int W = gpo_pkg::NUM_PINS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and sampled levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sample
);

  logic [W-1:0] next_sample;

  always_comb begin
    next_sample = pin_in;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample <= gpo_pkg::RESET_PINS[W-1:0];
    end else begin
      sample <= next_sample;
    end
  end

endmodule
`default_nettype wire

// [rtl/gpo_setclr_reg.sv]
// Pin register with plain write, write-one-to-set and write-one-to-clear.
// Assumes at most one command per cycle from the bus decoder.
`timescale 1ns/100ps
`default_nettype none
module gpo_setclr_reg #(
  parameter int W = gpo_pkg::NUM_PINS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Update command
  input wire gpo_pkg::gpo_cmd_type cmd,
  // Stored value
  output logic [W-1:0] q
);

  logic [W-1:0] next_q;
  logic [W-1:0] bits;

  always_comb begin
    bits = cmd.data[W-1:0] & cmd.mask[W-1:0];
    next_q = q;
    // [RULE_06] Zeros leave bits
    case (cmd.op)
      gpo_pkg::OP_WRITE: next_q = (q & ~cmd.mask[W-1:0]) | bits;
      gpo_pkg::OP_SET: next_q = q | bits;
      gpo_pkg::OP_CLEAR: next_q = q & ~bits;
      default: next_q = q;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= gpo_pkg::RESET_PINS[W-1:0];
    end else begin
      q <= next_q;
    end
  end

endmodule
`default_nettype wire

// [rtl/gpo_port.sv]
// GPIO port top: APB register file, pin output levels and directions.
// Assumes an APB master on clk and pins synchronous to clk.
//
// Operation
// [RULE_01] Low input register reads sampled levels of pins 0 to 15.
// [RULE_02] Writing one to high set bit 0 sets pin 16 level.
// [RULE_03] Ones written to low set register set matching low levels.
// [RULE_04] Writing one to high clear bit 0 clears pin 16 level.
// [RULE_05] Ones written to low clear register clear matching low levels.
// [RULE_06] Zeros written to any set or clear register change nothing.
// [RULE_07] High direction bit 0 is read-write and enables pin 16 driver.
// [RULE_08] Low direction register is read-write; ones enable pins 0 to 15.
// [RULE_09] Writing one to high direction-set bit 0 enables pin 16.
// [RULE_10] Ones written to low direction-set register enable matching pins.
// [RULE_11] Output level registers are read-write; readback gives stored value.
// [RULE_12] Unused high register bits read zero; all storage resets to zero.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module gpo_port #(
  parameter int NUM_PINS = gpo_pkg::NUM_PINS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpo_pkg::ADDR_W-1:0] paddr,
  input wire logic [gpo_pkg::DATA_W-1:0] pwdata,
  output logic [gpo_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n
);

  localparam int HB = gpo_pkg::HIGH_BIT;

  logic [NUM_PINS-1:0] pin_sample;
  logic [NUM_PINS-1:0] out_level;
  logic [NUM_PINS-1:0] out_enable;
  gpo_pkg::gpo_sel_type sel;
  logic access_start;
  logic access_done;
  logic write_done;
  logic [gpo_pkg::DATA_W-1:0] read_value;
  logic [gpo_pkg::DATA_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  gpo_pkg::gpo_cmd_type level_cmd;
  gpo_pkg::gpo_cmd_type enable_cmd;
  logic [NUM_PINS-1:0] next_pin_oe_n;

  // Address decode and APB phases
  assign sel = gpo_pkg::gpo_decode(
    paddr[gpo_pkg::IDX_W+gpo_pkg::IDX_LSB-1:gpo_pkg::IDX_LSB]);
  assign access_start = psel & penable & ~pready;
  assign access_done = psel & penable & pready;
  assign write_done = access_done & pwrite & ~pslverr;

  // Pin input sampling
  gpo_pin_sampler #(
    .W(NUM_PINS)
  ) u_sampler (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(pin_in),
    .sample(pin_sample)
  );

  // Output level register
  gpo_setclr_reg #(
    .W(NUM_PINS)
  ) u_level (
    .clk(clk),
    .rst_n(rst_n),
    .cmd(level_cmd),
    .q(out_level)
  );

  // Output enable register
  gpo_setclr_reg #(
    .W(NUM_PINS)
  ) u_enable (
    .clk(clk),
    .rst_n(rst_n),
    .cmd(enable_cmd),
    .q(out_enable)
  );

  // Read data selection
  always_comb begin
    // [RULE_12] Unused bits zero
    read_value = gpo_pkg::RESET_RDATA;
    case (sel)
      // [RULE_01] Sampled low pins
      gpo_pkg::SEL_PIN_INPUT_LOW:
        read_value[gpo_pkg::LOW_W-1:0] = pin_sample[gpo_pkg::LOW_W-1:0];
      // [RULE_11] Stored level readback
      gpo_pkg::SEL_OUTPUT_LEVEL_HIGH:
        read_value[0] = out_level[HB];
      gpo_pkg::SEL_OUTPUT_LEVEL_LOW:
        read_value[gpo_pkg::LOW_W-1:0] = out_level[gpo_pkg::LOW_W-1:0];
      // [RULE_07] Direction high readback
      gpo_pkg::SEL_OUTPUT_ENABLE_HIGH:
        read_value[0] = out_enable[HB];
      // [RULE_08] Direction low readback
      gpo_pkg::SEL_OUTPUT_ENABLE_LOW:
        read_value[gpo_pkg::LOW_W-1:0] = out_enable[gpo_pkg::LOW_W-1:0];
      default: read_value = gpo_pkg::RESET_RDATA;
    endcase
  end

  // APB answer: one wait state, error on unmapped index
  always_comb begin
    next_pready = access_start;
    next_pslverr = access_start & (sel == gpo_pkg::SEL_NONE);
    next_prdata = prdata;
    if (access_start) begin
      next_prdata = pwrite ? gpo_pkg::RESET_RDATA : read_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= gpo_pkg::RESET_RDATA;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Register update commands
  always_comb begin
    level_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_NONE, 1'b0, pwdata);
    enable_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_NONE, 1'b0, pwdata);
    if (write_done) begin
      case (sel)
        // [RULE_11] Plain level writes
        gpo_pkg::SEL_OUTPUT_LEVEL_HIGH:
          level_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_WRITE, 1'b1, pwdata);
        gpo_pkg::SEL_OUTPUT_LEVEL_LOW:
          level_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_WRITE, 1'b0, pwdata);
        // [RULE_02] Set pin 16
        gpo_pkg::SEL_OUTPUT_SET_HIGH:
          level_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_SET, 1'b1, pwdata);
        // [RULE_03] Set low levels
        gpo_pkg::SEL_OUTPUT_SET_LOW:
          level_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_SET, 1'b0, pwdata);
        // [RULE_04] Clear pin 16
        gpo_pkg::SEL_OUTPUT_CLEAR_HIGH:
          level_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_CLEAR, 1'b1, pwdata);
        // [RULE_05] Clear low levels
        gpo_pkg::SEL_OUTPUT_CLEAR_LOW:
          level_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_CLEAR, 1'b0, pwdata);
        // [RULE_07] Direction high write
        gpo_pkg::SEL_OUTPUT_ENABLE_HIGH:
          enable_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_WRITE, 1'b1, pwdata);
        // [RULE_08] Direction low write
        gpo_pkg::SEL_OUTPUT_ENABLE_LOW:
          enable_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_WRITE, 1'b0, pwdata);
        // [RULE_09] Enable pin 16
        gpo_pkg::SEL_OUTPUT_ENABLE_SET_HIGH:
          enable_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_SET, 1'b1, pwdata);
        // [RULE_10] Enable low pins
        gpo_pkg::SEL_OUTPUT_ENABLE_SET_LOW:
          enable_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_SET, 1'b0, pwdata);
        default: begin
          level_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_NONE, 1'b0, pwdata);
          enable_cmd = gpo_pkg::gpo_place(gpo_pkg::OP_NONE, 1'b0, pwdata);
        end
      endcase
    end
  end

  // Pin drive
  always_comb begin
    // [RULE_08] Enable drives low pins
    next_pin_oe_n = ~out_enable;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_n <= ~gpo_pkg::RESET_PINS[NUM_PINS-1:0];
      pin_out <= gpo_pkg::RESET_PINS[NUM_PINS-1:0];
    end else begin
      pin_oe_n <= next_pin_oe_n;
      pin_out <= out_level;
    end
  end

  // Bus sequences
  sequence s_write(logic [15:0] idx);
    psel && penable && pready && pwrite && !pslverr &&
      paddr[gpo_pkg::IDX_W+gpo_pkg::IDX_LSB-1:gpo_pkg::IDX_LSB] == idx;
  endsequence

  sequence s_read_start(logic [15:0] idx);
    psel && penable && !pready && !pwrite &&
      paddr[gpo_pkg::IDX_W+gpo_pkg::IDX_LSB-1:gpo_pkg::IDX_LSB] == idx;
  endsequence

  property p_input_low;
    @(posedge clk) disable iff (!rst_n)
      s_read_start(gpo_pkg::IDX_PIN_INPUT_LOW) |=>
        pready && prdata == {16'h0000, $past(pin_sample[15:0])};
  endproperty
  a_input_low: assert property (p_input_low) // [RULE_01]
    else $error("low input readback wrong");

  property p_set_high;
    @(posedge clk) disable iff (!rst_n)
      s_write(gpo_pkg::IDX_OUTPUT_SET_HIGH) ##0 pwdata[0] |=>
        out_level[HB] ##1 pin_out[HB];
  endproperty
  a_set_high: assert property (p_set_high) // [RULE_02]
    else $error("pin 16 level not set");

  property p_set_low;
    @(posedge clk) disable iff (!rst_n)
      s_write(gpo_pkg::IDX_OUTPUT_SET_LOW) |=>
        (out_level[15:0] & $past(pwdata[15:0])) == $past(pwdata[15:0]);
  endproperty
  a_set_low: assert property (p_set_low) // [RULE_03]
    else $error("low levels not set");

  property p_clear_high;
    @(posedge clk) disable iff (!rst_n)
      s_write(gpo_pkg::IDX_OUTPUT_CLEAR_HIGH) ##0 pwdata[0] |=>
        !out_level[HB] ##1 !pin_out[HB];
  endproperty
  a_clear_high: assert property (p_clear_high) // [RULE_04]
    else $error("pin 16 level not cleared");

  property p_clear_low;
    @(posedge clk) disable iff (!rst_n)
      s_write(gpo_pkg::IDX_OUTPUT_CLEAR_LOW) |=>
        (out_level[15:0] & $past(pwdata[15:0])) == 16'h0000;
  endproperty
  a_clear_low: assert property (p_clear_low) // [RULE_05]
    else $error("low levels not cleared");

  property p_zero_keeps;
    @(posedge clk) disable iff (!rst_n)
      (s_write(gpo_pkg::IDX_OUTPUT_SET_LOW) or
       s_write(gpo_pkg::IDX_OUTPUT_CLEAR_LOW)) |=>
        (out_level[15:0] & ~$past(pwdata[15:0])) ==
        ($past(out_level[15:0]) & ~$past(pwdata[15:0]));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) // [RULE_06]
    else $error("zero bits changed a level");

  property p_enable_high;
    @(posedge clk) disable iff (!rst_n)
      s_write(gpo_pkg::IDX_OUTPUT_ENABLE_HIGH) |=>
        out_enable[HB] == $past(pwdata[0]) ##1
        pin_oe_n[HB] == !$past(pwdata[0], 2);
  endproperty
  a_enable_high: assert property (p_enable_high) // [RULE_07]
    else $error("pin 16 driver enable wrong");

  property p_enable_low;
    @(posedge clk) disable iff (!rst_n)
      s_write(gpo_pkg::IDX_OUTPUT_ENABLE_LOW) |=>
        out_enable[15:0] == $past(pwdata[15:0]) ##1
        pin_oe_n[15:0] == ~$past(pwdata[15:0], 2);
  endproperty
  a_enable_low: assert property (p_enable_low) // [RULE_08]
    else $error("driver enables do not follow direction");

  property p_enable_set_high;
    @(posedge clk) disable iff (!rst_n)
      s_write(gpo_pkg::IDX_OUTPUT_ENABLE_SET_HIGH) ##0 pwdata[0] |=>
        out_enable[HB];
  endproperty
  a_enable_set_high: assert property (p_enable_set_high) // [RULE_09]
    else $error("pin 16 enable not set");

  property p_enable_set_low;
    @(posedge clk) disable iff (!rst_n)
      s_write(gpo_pkg::IDX_OUTPUT_ENABLE_SET_LOW) |=>
        (out_enable[15:0] & $past(pwdata[15:0])) == $past(pwdata[15:0]);
  endproperty
  a_enable_set_low: assert property (p_enable_set_low) // [RULE_10]
    else $error("low enables not set");

  property p_level_readback;
    @(posedge clk) disable iff (!rst_n)
      s_read_start(gpo_pkg::IDX_OUTPUT_LEVEL_LOW) |=>
        prdata == {16'h0000, $past(out_level[15:0])};
  endproperty
  a_level_readback: assert property (p_level_readback) // [RULE_11]
    else $error("level readback wrong");

  property p_high_zero;
    @(posedge clk) disable iff (!rst_n)
      pready && !pwrite && (sel == gpo_pkg::SEL_OUTPUT_LEVEL_HIGH ||
                            sel == gpo_pkg::SEL_OUTPUT_ENABLE_HIGH ||
                            sel == gpo_pkg::SEL_OUTPUT_SET_HIGH ||
                            sel == gpo_pkg::SEL_OUTPUT_CLEAR_HIGH ||
                            sel == gpo_pkg::SEL_OUTPUT_ENABLE_SET_HIGH) |->
        prdata[31:1] == 31'h00000000;
  endproperty
  a_high_zero: assert property (p_high_zero) // [RULE_12]
    else $error("unused high bits not zero");

endmodule
`default_nettype wire

// [bench/gpo_board.sv]
// Board model for the pin side: drives a level on every undriven pin.
// Assumes active-low enables; a driven pin reads back the port's level.
`timescale 1ns/100ps
`default_nettype none
module gpo_board #(
  parameter int W = 17
) (
  // Port side
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  // Board side
  input wire logic [W-1:0] ext_level,
  output logic [W-1:0] pin_in
);
  // Resolved wire level per pin
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule
`default_nettype wire

// [bench/tb_gpo_port.sv]
// Self-checking bench for the GPIO port over APB.
// Assumes gpo_pkg and the port design are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_gpo_port;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [16:0] pin_in, pin_out, pin_oe_n, ext_level;
  logic [15:0] idx_list [11];
  logic [31:0] exp_v;
  int n_errors, samples_checked;

  gpo_port DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  gpo_board #(.W(17)) board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext_level), .pin_in(pin_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd, output logic [31:0] rdv,
                     output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) check("pready", 32'h0, 32'h1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, wd, d, e);
    check("write err", {31'h0, e}, 32'h0);
  endtask

  task automatic rd(input string name, input logic [15:0] idx,
                    input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0, d, e);
    check(name, d, exp);
    check("read err", {31'h0, e}, 32'h0);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] d;
    logic e;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
    ext_level = 17'h00000;
    n_errors = 0;
    samples_checked = 0;
    idx_list = '{gpo_pkg::IDX_PIN_INPUT_LOW, gpo_pkg::IDX_OUTPUT_LEVEL_HIGH,
      gpo_pkg::IDX_OUTPUT_LEVEL_LOW, gpo_pkg::IDX_OUTPUT_SET_HIGH,
      gpo_pkg::IDX_OUTPUT_SET_LOW, gpo_pkg::IDX_OUTPUT_CLEAR_HIGH,
      gpo_pkg::IDX_OUTPUT_CLEAR_LOW, gpo_pkg::IDX_OUTPUT_ENABLE_HIGH,
      gpo_pkg::IDX_OUTPUT_ENABLE_LOW, gpo_pkg::IDX_OUTPUT_ENABLE_SET_HIGH,
      gpo_pkg::IDX_OUTPUT_ENABLE_SET_LOW};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values
    foreach (idx_list[i]) rd("reset value", idx_list[i], 32'h0);
    check("pin_oe_n", {15'h0, pin_oe_n}, 32'h0001FFFF);
    check("pin_out", {15'h0, pin_out}, 32'h0);
    $display("test reset done");
    // Output levels
    wr(gpo_pkg::IDX_OUTPUT_LEVEL_LOW, 32'hFFFFA5A5);
    rd("level low", gpo_pkg::IDX_OUTPUT_LEVEL_LOW, 32'hA5A5);
    wr(gpo_pkg::IDX_OUTPUT_SET_LOW, 32'h00000F00);
    rd("set low", gpo_pkg::IDX_OUTPUT_LEVEL_LOW, 32'hAFA5);
    wr(gpo_pkg::IDX_OUTPUT_CLEAR_LOW, 32'h000000A0);
    rd("clear low", gpo_pkg::IDX_OUTPUT_LEVEL_LOW, 32'hAF05);
    wr(gpo_pkg::IDX_OUTPUT_LEVEL_HIGH, 32'h00000001);
    rd("level high", gpo_pkg::IDX_OUTPUT_LEVEL_HIGH, 32'h1);
    wr(gpo_pkg::IDX_OUTPUT_CLEAR_HIGH, 32'hFFFFFFFE);
    rd("clear zeros", gpo_pkg::IDX_OUTPUT_LEVEL_HIGH, 32'h1);
    wr(gpo_pkg::IDX_OUTPUT_CLEAR_HIGH, 32'h00000001);
    rd("clear high", gpo_pkg::IDX_OUTPUT_LEVEL_HIGH, 32'h0);
    wr(gpo_pkg::IDX_OUTPUT_SET_HIGH, 32'hFFFFFFFF);
    rd("set high", gpo_pkg::IDX_OUTPUT_LEVEL_HIGH, 32'h1);
    repeat (3) @(posedge clk);
    check("pin_out", {15'h0, pin_out}, 32'h0001AF05);
    $display("test levels done");
    // Directions
    wr(gpo_pkg::IDX_OUTPUT_ENABLE_LOW, 32'h00001234);
    rd("dir low", gpo_pkg::IDX_OUTPUT_ENABLE_LOW, 32'h1234);
    wr(gpo_pkg::IDX_OUTPUT_ENABLE_SET_LOW, 32'h00008001);
    rd("dir set low", gpo_pkg::IDX_OUTPUT_ENABLE_LOW, 32'h9235);
    wr(gpo_pkg::IDX_OUTPUT_ENABLE_SET_LOW, 32'h00000000);
    rd("dir set zero", gpo_pkg::IDX_OUTPUT_ENABLE_LOW, 32'h9235);
    wr(gpo_pkg::IDX_OUTPUT_ENABLE_HIGH, 32'hFFFFFFFE);
    rd("dir high", gpo_pkg::IDX_OUTPUT_ENABLE_HIGH, 32'h0);
    wr(gpo_pkg::IDX_OUTPUT_ENABLE_SET_HIGH, 32'h00000001);
    rd("dir set high", gpo_pkg::IDX_OUTPUT_ENABLE_HIGH, 32'h1);
    repeat (3) @(posedge clk);
    check("pin_oe_n", {15'h0, pin_oe_n}, {15'h0, ~17'h19235});
    $display("test directions done");
    // Pin input readback, some pins driven
    ext_level <= 17'h0C33C;
    repeat (3) @(posedge clk);
    exp_v = {16'h0, (16'hAF05 & 16'h9235) | (16'hC33C & ~16'h9235)};
    rd("input mixed", gpo_pkg::IDX_PIN_INPUT_LOW, exp_v);
    wr(gpo_pkg::IDX_OUTPUT_ENABLE_LOW, 32'h00000000);
    wr(gpo_pkg::IDX_OUTPUT_ENABLE_HIGH, 32'h00000000);
    rd("dir high off", gpo_pkg::IDX_OUTPUT_ENABLE_HIGH, 32'h0);
    ext_level <= 17'h13CC3;
    repeat (3) @(posedge clk);
    rd("input free", gpo_pkg::IDX_PIN_INPUT_LOW, 32'h3CC3);
    check("pin_oe_n", {15'h0, pin_oe_n}, 32'h0001FFFF);
    $display("test inputs done");
    // Read-only and unmapped places
    wr(gpo_pkg::IDX_PIN_INPUT_LOW, 32'h0000FFFF);
    rd("input ro", gpo_pkg::IDX_PIN_INPUT_LOW, 32'h3CC3);
    apb(1'b0, 16'h4700, 32'h0, d, e);
    check("unmapped rdata", d, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    apb(1'b1, 16'h4710, 32'hFFFFFFFF, d, e);
    check("unmapped werr", {31'h0, e}, 32'h1);
    rd("level kept", gpo_pkg::IDX_OUTPUT_LEVEL_LOW, 32'hAF05);
    $display("test refusals done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
